//--- hdl/arc_bias_if.sv
// Carrier between the register core and the bias merge stage.
// Assumes both ends share sys_clk.
`timescale 1ns/1ns
`default_nettype none
interface arc_bias_if;
   logic ce;
   logic rst_n;
   logic sw_bias;
   logic adc_req;
   logic temp_req;
   logic osc_req;
   logic bias_on;
   modport core  (output ce, rst_n, sw_bias, adc_req, temp_req, osc_req, input bias_on);
   modport merge (input ce, rst_n, sw_bias, adc_req, temp_req, osc_req, output bias_on);
endinterface
`default_nettype wire

//--- hdl/arc_bias_merge.sv
// Bias generator enable merge: software bit or any peripheral request.
// Assumes all requests come from logic on sys_clk.
`timescale 1ns/1ns
`default_nettype none
module arc_bias_merge
   import arc_pkg::*;
(
   input  wire logic  sys_clk,
   arc_bias_if.merge  bif
);
   arc_bias_state_s st_q;
   arc_bias_state_s st_d;

   always_comb
   begin
      st_d = st_q;
      if (bif.ce)
      begin
         // Peripheral requests force the bias on whatever software wrote.
         st_d.bias_on = bif.sw_bias | bif.adc_req | bif.temp_req | bif.osc_req;
      end
   end

   always_ff @(posedge sys_clk or negedge bif.rst_n)
   begin
      if (!bif.rst_n)
         st_q <= '0;
      else
         st_q <= st_d;
   end

   assign bif.bias_on = st_q.bias_on;
endmodule
`default_nettype wire

//--- hdl/arc_params.svh
// Register address, field positions, masks and reset value of the reference control block.
// Assumes it is included by bare name from files that need these constants.
`ifndef ARC_PARAMS_SVH
`define ARC_PARAMS_SVH
`define ARC_CTRL_ADDR   8'hd1
`define ARC_CTRL_RESET  8'h00
`define ARC_BIT_REFSEL  3
`define ARC_BIT_TEMPEN  2
`define ARC_BIT_BIASEN  1
`define ARC_CTRL_WMASK  8'h0e
`define ARC_RDATA_IDLE  8'h00
`define ARC_AMUX_W_DEF  5
`define ARC_AMUX_W_MAX  8
`endif

//--- hdl/arc_pkg.sv
// Types shared by the analog reference control modules.
// Assumes arc_params.svh is on the include path.
`default_nettype none
package arc_pkg;
   typedef struct packed
   {
      logic [7:0] ctrl;
      logic [7:0] rdata;
      logic       hit;
      logic       tsense_oe;
      logic       tsense_route;
   } arc_state_s;

   typedef struct packed
   {
      logic bias_on;
   } arc_bias_state_s;
endpackage
`default_nettype wire

//--- hdl/arc_top.sv
// Analog reference control register and its analog enables.
// Assumes a byte-wide special-function register bus and ADC/oscillator enables on sys_clk.
`timescale 1ns/1ns
`default_nettype none
`include "arc_params.svh"
module arc_top
   import arc_pkg::*;
#(
   parameter int AMUX_W = `ARC_AMUX_W_DEF
)
(
   input  wire logic              sys_clk,
   input  wire logic              arst_n,
   input  wire logic              ce,
   input  wire logic [7:0]        sfr_addr,
   input  wire logic              sfr_wr,
   input  wire logic              sfr_rd,
   input  wire logic [7:0]        sfr_wdata,
   output logic      [7:0]        sfr_rdata,
   output logic                   sfr_hit,
   input  wire logic              adc_enable,
   input  wire logic              osc_enable,
   input  wire logic [AMUX_W-1:0] amux_pos_sel,
   output logic                   ref_source_select,
   output logic                   temp_sensor_enable,
   output logic                   bias_gen_enable,
   output logic                   temp_sensor_oe,
   output logic                   temp_sensor_routed
);

   ////////////////////////////////////////////////////////////////////////////
   // Elaboration checks.

   if (AMUX_W < 1 || AMUX_W > `ARC_AMUX_W_MAX)
   begin : g_bad_width
      $error("AMUX_W out of range");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Reset release. Assertion is asynchronous; release is aligned to sys_clk
   // so the register never leaves reset on a partial edge.

   logic rst_meta_q;
   logic rst_sync_q;

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end
      else
      begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Helpers.

   function automatic logic addr_hit(input logic [7:0] a);
      return a == `ARC_CTRL_ADDR;
   endfunction

   function automatic logic [7:0] ctrl_view(input logic [7:0] c);
      return c & `ARC_CTRL_WMASK;
   endfunction

   localparam logic [AMUX_W-1:0] AMUX_TOP = '1;

   ////////////////////////////////////////////////////////////////////////////
   // Register state.

   arc_state_s st_q;
   arc_state_s st_d;
   logic       wr_hit;
   logic       rd_hit;

   assign wr_hit = sfr_wr && addr_hit(sfr_addr);
   assign rd_hit = sfr_rd && addr_hit(sfr_addr);

   always_comb
   begin
      st_d = st_q;
      if (ce)
      begin
         st_d.hit = rd_hit;
         if (wr_hit)
         begin
            // Unused bits never reach storage, so no later read can show them.
            st_d.ctrl = ctrl_view(sfr_wdata);
         end
         if (rd_hit)
            st_d.rdata = ctrl_view(st_q.ctrl);
         else
            st_d.rdata = `ARC_RDATA_IDLE;
         // The sensor drives its mux leg only while enabled; otherwise that
         // input floats and conversions on it are meaningless.
         st_d.tsense_oe    = st_d.ctrl[`ARC_BIT_TEMPEN];
         st_d.tsense_route = st_d.ctrl[`ARC_BIT_TEMPEN] && (amux_pos_sel == AMUX_TOP);
      end
   end

   always_ff @(posedge sys_clk or negedge rst_sync_q)
   begin
      if (!rst_sync_q)
      begin
         st_q              <= '0;
         st_q.ctrl         <= `ARC_CTRL_RESET;
         st_q.rdata        <= `ARC_RDATA_IDLE;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bias merge.

   arc_bias_if bif ();

   assign bif.ce       = ce;
   assign bif.rst_n    = rst_sync_q;
   assign bif.sw_bias  = st_q.ctrl[`ARC_BIT_BIASEN];
   assign bif.adc_req  = adc_enable;
   assign bif.temp_req = st_q.ctrl[`ARC_BIT_TEMPEN];
   assign bif.osc_req  = osc_enable;

   arc_bias_merge u_merge
   (
      .sys_clk (sys_clk),
      .bif     (bif)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Outputs, each taken straight from a flop.

   assign sfr_rdata          = st_q.rdata;
   assign sfr_hit            = st_q.hit;
   assign ref_source_select  = st_q.ctrl[`ARC_BIT_REFSEL];
   assign temp_sensor_enable = st_q.ctrl[`ARC_BIT_TEMPEN];
   assign bias_gen_enable    = bif.bias_on;
   assign temp_sensor_oe     = st_q.tsense_oe;
   assign temp_sensor_routed = st_q.tsense_route;

   ////////////////////////////////////////////////////////////////////////////
   // Checks.

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_sync_q);

   sequence s_write;
      ce && wr_hit;
   endsequence

   sequence s_read;
      ce && rd_hit;
   endsequence

   sequence s_force;
      ce && (adc_enable || osc_enable || temp_sensor_enable);
   endsequence

   chk_ref_select_wr: assert property (s_write |=> ref_source_select == $past(sfr_wdata[`ARC_BIT_REFSEL]))
      else $error("reference select did not follow write");

   chk_temp_enable_wr: assert property (s_write |=> temp_sensor_enable == $past(sfr_wdata[`ARC_BIT_TEMPEN]))
      else $error("sensor enable did not follow write");

   chk_bias_sw_on: assert property ((s_write ##0 sfr_wdata[`ARC_BIT_BIASEN]) ##1 ce
                                    |=> bias_gen_enable)
      else $error("software bias bit did not turn bias on");

   chk_bias_forced: assert property (s_force |=> bias_gen_enable)
      else $error("bias not forced by peripheral");

   chk_unused_zero: assert property ((sfr_rdata & ~`ARC_CTRL_WMASK) == `ARC_RDATA_IDLE)
      else $error("unused bits read nonzero");

   // A read in the same cycle as a write must return the value held before that write.
   chk_read_value: assert property (s_read |=> sfr_hit &&
      sfr_rdata[`ARC_BIT_REFSEL:`ARC_BIT_BIASEN] == $past(st_q.ctrl[`ARC_BIT_REFSEL:`ARC_BIT_BIASEN]))
      else $error("read data does not match register");

   chk_other_addr: assert property (ce && sfr_wr && !addr_hit(sfr_addr) |=> $stable(st_q.ctrl))
      else $error("write to other address changed register");

   chk_sensor_route: assert property (temp_sensor_routed |-> temp_sensor_oe && temp_sensor_enable)
      else $error("sensor routed while disabled");

   chk_sensor_float: assert property (ce && !st_d.ctrl[`ARC_BIT_TEMPEN] |=> !temp_sensor_oe ##0 !temp_sensor_routed)
      else $error("disabled sensor still driven");

   chk_bias_idle_off: assert property (ce && !adc_enable && !osc_enable && !st_q.ctrl[`ARC_BIT_BIASEN]
                                       && !st_q.ctrl[`ARC_BIT_TEMPEN] |=> !bias_gen_enable)
      else $error("bias on with no request");

   chk_rdata_idle: assert property (ce && !rd_hit |=> !sfr_hit && sfr_rdata == `ARC_RDATA_IDLE)
      else $error("read data or hit shown without a read");

   // A low enable must hold every stored bit, the merged bias output included.
   chk_ctrl_freeze: assert property (!ce |=> $stable(st_q) && $stable(bias_gen_enable))
      else $error("state changed while clock enable low");

endmodule
`default_nettype wire

//--- test/analog_reference_control_bench.sv
// Self-checking bench for the reference control register block.
// Assumes arc_top with its default mux width; inputs move at the falling edge.
`timescale 1ns/1ns
`default_nettype none
module analog_reference_control_bench;
   logic       sys_clk = 0;
   logic       arst_n = 0;
   logic       ce = 1;
   logic       wr = 0;
   logic       rd = 0;
   logic       adc = 0;
   logic       osc = 0;
   logic [7:0] addr = 0;
   logic [7:0] wd = 0;
   logic [7:0] m = 0;
   logic [4:0] mux = 0;
   logic [7:0] rdata;
   logic       hit, rsel, ten, bias, oe, rt;
   logic [7:0] q[$];
   int         n_errors = 0;
   int         total_checks = 0;
   int         cyc = 0;
   // Entries with bit 3 clear select the external reference pin.
   logic [7:0] tab[5] = '{8'h08, 8'h04, 8'h02, 8'h00, 8'hff};

   initial forever #4 sys_clk = ~sys_clk;

   arc_top uut (.sys_clk(sys_clk), .arst_n(arst_n), .ce(ce), .sfr_addr(addr), .sfr_wr(wr),
      .sfr_rd(rd), .sfr_wdata(wd), .sfr_rdata(rdata), .sfr_hit(hit), .adc_enable(adc),
      .osc_enable(osc), .amux_pos_sel(mux), .ref_source_select(rsel),
      .temp_sensor_enable(ten), .bias_gen_enable(bias), .temp_sensor_oe(oe),
      .temp_sensor_routed(rt));

   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input string nm, input logic [7:0] s, input logic [7:0] e);
      total_checks++;
      if (s !== e)
      begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", nm, e, s);
      end
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic wr8(input logic [7:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      addr = a;
      wd = d;
      wr = 1;
      if (a == 8'hd1 && ce)
         m = d & 8'h0e;
      @(negedge sys_clk);
      wr = 0;
   endtask

   task automatic rd8(input logic [7:0] a);
      @(negedge sys_clk);
      addr = a;
      rd = 1;
      if (a == 8'hd1)
         q.push_back(m);
      @(negedge sys_clk);
      rd = 0;
      if (a != 8'hd1)
      begin
         check("stray_hit", {7'h00, hit}, 8'h00);
         check("stray_rdata", rdata, 8'h00);
      end
   endtask

   // The bias output lags the stored bit by one extra cycle, so one more edge is let pass.
   task automatic outs();
      @(negedge sys_clk);
      check("rsel", {7'h00, rsel}, {7'h00, m[3]});
      check("tsen", {7'h00, ten}, {7'h00, m[2]});
      check("bias", {7'h00, bias}, {7'h00, m[1] | m[2] | adc | osc});
      check("ts_oe", {7'h00, oe}, {7'h00, m[2]});
      check("routed", {7'h00, rt}, {7'h00, m[2] & (&mux)});
   endtask

   ////////////////////////////////////////////////////////////////////////////
   always @(negedge sys_clk)
      if (hit === 1'b1)
      begin
         if (q.size() == 0)
            check("extra_hit", 8'h01, 8'h00);
         else
            check("rdata", rdata, q.pop_front());
      end

   always @(posedge sys_clk)
   begin
      cyc++;
      if (cyc == 2000)
      begin
         n_errors++;
         final_report();
      end
   end

   initial
   begin
      void'($urandom(61721));
      repeat (6) @(negedge sys_clk);
      arst_n = 1;
      repeat (3) @(negedge sys_clk);
      outs();
      rd8(8'hd1);
      $display("test reset done");
      foreach (tab[i])
      begin
         wr8(8'hd1, tab[i]);
         outs();
         rd8(8'hd1);
      end
      $display("test fields done");
      wr8(8'hd0, 8'h00);
      wr8(8'hd2, 8'h00);
      outs();
      rd8(8'hd0);
      rd8(8'hd1);
      $display("test unmapped done");
      wr8(8'hd1, 8'h00);
      for (int i = 0; i < 4; i++)
      begin
         {adc, osc} = 2'(i);
         outs();
      end
      {adc, osc} = 2'h0;
      outs();
      $display("test force done");
      wr8(8'hd1, 8'h04);
      mux = '1;
      outs();
      mux = 5'h1e;
      outs();
      mux = '1;
      wr8(8'hd1, 8'h00);
      outs();
      $display("test routing done");
      @(negedge sys_clk);
      addr = 8'hd1;
      wd = 8'h08;
      wr = 1;
      rd = 1;
      q.push_back(m);
      m = 8'h08;
      @(negedge sys_clk);
      wr = 0;
      rd = 0;
      outs();
      $display("test overlap done");
      ce = 0;
      wr8(8'hd1, 8'h0e);
      ce = 1;
      outs();
      wr8(8'hd1, 8'h0e);
      arst_n = 0;
      m = 0;
      repeat (2) @(negedge sys_clk);
      arst_n = 1;
      repeat (2) @(negedge sys_clk);
      outs();
      rd8(8'hd1);
      $display("test freeze and reset done");
      for (int i = 0; i < 30; i++)
      begin
         mux = 5'($urandom());
         adc = 1'($urandom());
         osc = 1'($urandom());
         wr8(8'hd1, 8'($urandom()) | {6'h00, adc, 1'b0});
         outs();
         rd8(8'hd1);
      end
      repeat (2) @(negedge sys_clk);
      check("pending", 8'(q.size()), 8'h00);
      $display("test random done");
      final_report();
   end
endmodule
`default_nettype wire
